// [fks_pkg.sv]
// Package for the keyed flash program/erase sequencer.
// Assumes a 25 MHz system clock and an 8-bit processor-side write port.
package fks_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int ADDR_W = 14;
  localparam int PAGE_BITS = 9;
  localparam int PAGE_BYTES = 512;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] USER_TOP = 14'h3DFF;
  localparam int PSC_WRITE_BIT = 0;
  localparam int PSC_ERASE_BIT = 1;
  localparam logic [1:0] PSC_RESET = 2'h0;
  // Least program and erase times, in microseconds
  localparam int WRITE_TIME_US = 40;
  localparam int ERASE_TIME_US = 10000;
  localparam int WRITE_CYCLES = (WRITE_TIME_US * (CLK_HZ / 1000000));
  localparam int ERASE_CYCLES = (ERASE_TIME_US * (CLK_HZ / 1000000));
  typedef enum logic [1:0] {FKS_KEY_IDLE, FKS_KEY_HALF, FKS_KEY_OPEN,
                            FKS_KEY_DEAD} fks_key_t;
  typedef enum logic [1:0] {FKS_IDLE, FKS_PROG, FKS_ERASE,
                            FKS_WAIT} fks_state_t;
endpackage : fks_pkg

// [fks_mem.sv]
// Byte-wide array model of the nonvolatile store.
// Assumes one write and one read per cycle; read data are registered.
`timescale 1ns/1ps
module fks_mem import fks_pkg::*; #(
  parameter int AW = ADDR_W
) (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : fks_mem

// [fks_timer.sv]
// Down counter that times one program or erase operation.
// Assumes i_start is a one-cycle pulse while idle.
`timescale 1ns/1ps
module fks_timer #(
  parameter int CW = 20
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [CW-1:0] i_count,
  output logic o_done
);
  logic [CW-1:0] count;
  logic running;
  wire logic last = running && (count == '0);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= '0;
      running <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (i_start) begin
        count <= i_count;
        running <= 1'b1;
      end else if (last) begin
        running <= 1'b0;
      end else if (running) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : fks_timer

// [fks_sequencer.sv]
// Keyed program/erase sequencer for the on-chip code store.
// Assumes the core gives one-cycle write/read strobes on i_mclk and waits
// while o_stall is high; debug-port strobes come from logic on i_mclk.
`timescale 1ns/1ps
module fks_sequencer import fks_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter int ERASE_CNT = ERASE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ctl_we,
  input wire logic [7:0] i_ctl_wdata,
  input wire logic i_key_we,
  input wire logic [7:0] i_key_wdata,
  input wire logic i_move_we,
  input wire logic i_move_re,
  input wire logic [15:0] i_move_addr,
  input wire logic [7:0] i_move_wdata,
  input wire logic i_dbg_we,
  input wire logic [AW-1:0] i_dbg_addr,
  input wire logic [7:0] i_dbg_wdata,
  input wire logic i_code_re,
  input wire logic [AW-1:0] i_code_addr,
  output logic [7:0] o_code_rdata,
  output logic [7:0] o_psc,
  output logic o_stall,
  output logic o_external_data_ram_we,
  output logic o_external_data_ram_re,
  output logic [15:0] o_external_data_ram_addr,
  output logic [7:0] o_external_data_ram_wdata,
  output logic o_sys_reset_req,
  output logic o_nv_error_flag,
  output logic o_locked_out
);
  logic store_write_enable;
  logic store_erase_enable;
  fks_key_t key;
  fks_key_t next_key;
  fks_state_t state;
  fks_state_t next_state;
  logic [AW-1:0] op_addr;
  logic [7:0] op_data;
  logic [PAGE_BITS-1:0] page_idx;
  logic dbg_pend;
  logic [7:0] mem_rdata;
  logic timer_done;

  // Array reads share one port: code reads go through it while idle
  wire logic busy = (state != FKS_IDLE);
  wire logic to_array = i_move_we && store_write_enable;
  wire logic above_top = (i_move_addr > {2'h0, USER_TOP});
  wire logic key_open = (key == FKS_KEY_OPEN);
  wire logic start_op = to_array && !busy && key_open && !above_top;
  wire logic want_erase = store_erase_enable;
  // Above-top attempts only raise the error and a reset request; they never touch the key
  wire logic bad_try = to_array && !busy && !key_open && !above_top;
  wire logic [AW-1:0] page_base = {op_addr[AW-1:PAGE_BITS],
                                   {PAGE_BITS{1'b0}}};
  wire logic mem_we = (state == FKS_PROG && timer_done) ||
                      (state == FKS_ERASE);
  wire logic [AW-1:0] mem_waddr = (state == FKS_ERASE) ?
                                  (page_base | AW'(page_idx)) : op_addr;
  // Program ANDs in the new data, so it can only clear bits
  wire logic [7:0] mem_wdata = (state == FKS_ERASE) ? ERASED_BYTE :
                               (mem_rdata & op_data);
  wire logic [AW-1:0] mem_raddr = busy ? op_addr : i_code_addr;
  wire logic start_any = start_op || (dbg_pend && !busy);
  wire logic erase_end = (state == FKS_ERASE) &&
                         (page_idx == PAGE_BITS'(PAGE_BYTES - 1));
  // Erase time starts once the page is cleared, so the wait state sees done
  wire logic timer_go = (start_any && !(start_op && want_erase)) ||
                        erase_end;
  wire logic [19:0] op_len = erase_end ? 20'(ERASE_CNT) :
                             20'(WRITE_CNT);

  fks_mem #(.AW(AW)) u_mem (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  fks_timer #(.CW(20)) u_timer (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_start(timer_go),
    .i_count(op_len),
    .o_done(timer_done)
  );

  // Key tracking; timing between writes is never checked
  always_comb begin
    next_key = key;
    if (key != FKS_KEY_DEAD) begin
      if (i_key_we) begin
        case (key)
          FKS_KEY_IDLE: next_key = (i_key_wdata == KEY_FIRST) ?
                                   FKS_KEY_HALF : FKS_KEY_DEAD;
          FKS_KEY_HALF: next_key = (i_key_wdata == KEY_SECOND) ?
                                   FKS_KEY_OPEN : FKS_KEY_DEAD;
          default: next_key = FKS_KEY_DEAD;
        endcase
      end else if (bad_try) begin
        next_key = FKS_KEY_DEAD;
      end else if (start_op) begin
        next_key = FKS_KEY_IDLE;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      FKS_IDLE: begin
        if (start_op && want_erase) begin
          next_state = FKS_ERASE;
        end else if (start_any) begin
          next_state = FKS_PROG;
        end
      end
      FKS_PROG: if (timer_done) next_state = FKS_IDLE;
      FKS_ERASE: if (page_idx == PAGE_BITS'(PAGE_BYTES - 1))
                   next_state = FKS_WAIT;
      FKS_WAIT: if (timer_done) next_state = FKS_IDLE;
      default: next_state = FKS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      store_write_enable <= PSC_RESET[PSC_WRITE_BIT];
      store_erase_enable <= PSC_RESET[PSC_ERASE_BIT];
      key <= FKS_KEY_IDLE;
      state <= FKS_IDLE;
      op_addr <= '0;
      op_data <= 8'h00;
      page_idx <= '0;
      dbg_pend <= 1'b0;
    end else begin
      if (i_ctl_we) begin
        store_write_enable <= i_ctl_wdata[PSC_WRITE_BIT];
        store_erase_enable <= i_ctl_wdata[PSC_ERASE_BIT];
      end
      key <= next_key;
      state <= next_state;
      if (i_dbg_we) begin
        dbg_pend <= 1'b1;
      end else if (!busy && !start_op) begin
        dbg_pend <= 1'b0;
      end
      // Move writes win the port; a debug write waits until the sequencer is idle again
      if (start_op) begin
        op_addr <= i_move_addr[AW-1:0];
        op_data <= i_move_wdata;
      end else if (dbg_pend && !busy) begin
        op_addr <= i_dbg_addr;
        op_data <= i_dbg_wdata;
      end
      page_idx <= (state == FKS_ERASE) ? page_idx + 1'b1 : '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_code_rdata <= 8'h00;
      o_psc <= 8'h00;
      o_stall <= 1'b0;
      o_external_data_ram_we <= 1'b0;
      o_external_data_ram_re <= 1'b0;
      o_external_data_ram_addr <= 16'h0000;
      o_external_data_ram_wdata <= 8'h00;
      o_sys_reset_req <= 1'b0;
      o_nv_error_flag <= 1'b0;
      o_locked_out <= 1'b0;
    end else begin
      // Stale during an operation, but the core is stalled then anyway
      o_code_rdata <= mem_rdata;
      if (i_ctl_we) begin
        o_psc <= {6'h00, i_ctl_wdata[PSC_ERASE_BIT],
                  i_ctl_wdata[PSC_WRITE_BIT]};
      end
      o_stall <= (next_state != FKS_IDLE);
      o_external_data_ram_we <= i_move_we && !store_write_enable;
      o_external_data_ram_re <= i_move_re;
      if (i_move_we || i_move_re) begin
        o_external_data_ram_addr <= i_move_addr;
        o_external_data_ram_wdata <= i_move_wdata;
      end
      o_sys_reset_req <= to_array && above_top;
      if (to_array && above_top) begin
        o_nv_error_flag <= 1'b1;
      end
      o_locked_out <= (next_key == FKS_KEY_DEAD);
    end
  end
endmodule : fks_sequencer

// [fks_sequencer_assertions.sv]
// Port checker for the keyed flash sequencer.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module fks_sequencer_assertions (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ctl_we,
  input wire logic [7:0] i_ctl_wdata,
  input wire logic i_move_we,
  input wire logic i_move_re,
  input wire logic [7:0] o_psc,
  input wire logic o_stall,
  input wire logic o_external_data_ram_we,
  input wire logic o_external_data_ram_re,
  input wire logic o_nv_error_flag,
  input wire logic o_locked_out
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  AST_LOCK_HOLD: assert property (o_locked_out |=> o_locked_out)
    else $error("lockout dropped");
  AST_ERR_HOLD: assert property (o_nv_error_flag |=> o_nv_error_flag)
    else $error("error flag dropped");
  AST_EXTERNAL_DATA_RAM_WR: assert property (i_move_we && !o_psc[0] && !o_stall
    && !i_ctl_we |=> o_external_data_ram_we) else $error("move write lost");
  AST_EXTERNAL_DATA_RAM_RD: assert property (i_move_re && !o_stall |=> o_external_data_ram_re)
    else $error("move read lost");
  AST_PSC_HOLD: assert property (!i_ctl_we |=> $stable(o_psc))
    else $error("control changed");
  AST_PSC_WR: assert property (i_ctl_we |=>
    o_psc == {6'h00, $past(i_ctl_wdata[1:0])}) else $error("control bad");
  AST_STALL_END: assert property ($rose(o_stall) |-> ##[1:1000] !o_stall)
    else $error("stall too long");
  AST_LOCK_NO_OP: assert property (o_locked_out && i_move_we && !o_stall
    |=> !o_stall) else $error("op while blocked");
  cover property ($rose(o_stall));
  cover property ($rose(o_locked_out));
  cover property ($rose(o_nv_error_flag));
endmodule : fks_sequencer_assertions

// [fks_core_model.sv]
// Processor core model issuing control, key and move strobes.
// Assumes the sequencer holds it off through i_stall.
`timescale 1ns/1ps
module fks_core_model (
  input wire logic i_mclk,
  input wire logic i_stall,
  output logic o_ctl_we = 1'b0,
  output logic o_key_we = 1'b0,
  output logic o_move_we = 1'b0,
  output logic o_move_re = 1'b0,
  output logic [15:0] o_addr = 16'h0000,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_hang = 1'b0
);
  int tmo;
  // Kind 0 control, 1 key, 2 move write, 3 move read
  task automatic wr(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {o_ctl_we, o_key_we, o_move_we, o_move_re} <= 4'h8 >> k;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    {o_ctl_we, o_key_we, o_move_we, o_move_re} <= 4'h0;
    // Released data never repeats the last value
    o_wdata <= ~d;
    @(posedge i_mclk);
    @(negedge i_mclk);
    for (tmo = 0; i_stall !== 1'b0 && tmo < 2000; tmo++)
      @(negedge i_mclk);
    if (tmo >= 2000)
      o_hang = 1'b1;
  endtask : wr
  // Keys are sent again before every single operation
  task automatic op(input logic [15:0] a, input logic [7:0] d);
    wr(1, 16'h0000, 8'hA5);
    wr(1, 16'h0000, 8'hF1);
    wr(2, a, d);
  endtask : op
endmodule : fks_core_model

// [test_flash_program_erase_keyed_sequencer.sv]
// Self-checking bench for the keyed flash sequencer.
// Assumes short op timing parameters and the core model on the far side.
`timescale 1ns/1ps
module test_flash_program_erase_keyed_sequencer;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_dbg_we = 1'b0;
  logic [13:0] i_dbg_addr = 14'h0000;
  logic [7:0] i_dbg_wdata = 8'h00;
  logic [13:0] i_code_addr = 14'h0000;
  logic i_ctl_we, i_key_we, i_move_we, i_move_re, o_stall, o_external_data_ram_we;
  logic o_external_data_ram_re, o_sys_reset_req, o_nv_error_flag, o_locked_out, hang;
  logic [15:0] ad, o_external_data_ram_addr;
  logic [15:0] xa = 16'h0000;
  logic [7:0] wd, o_code_rdata, o_psc, o_external_data_ram_wdata;
  int xr = 0;
  int bad_count = 0;
  int check_count = 0;
  fks_sequencer #(.WRITE_CNT(4), .ERASE_CNT(8)) dut (.i_mclk, .i_reset_n,
    .i_ctl_we, .i_ctl_wdata(wd), .i_key_we, .i_key_wdata(wd), .i_move_we,
    .i_move_re, .i_move_addr(ad), .i_move_wdata(wd), .i_dbg_we, .i_dbg_addr,
    .i_dbg_wdata, .i_code_re(1'b0), .i_code_addr, .o_code_rdata, .o_psc,
    .o_stall, .o_external_data_ram_we, .o_external_data_ram_re, .o_external_data_ram_addr, .o_external_data_ram_wdata,
    .o_sys_reset_req, .o_nv_error_flag, .o_locked_out);
  fks_core_model core (.i_mclk, .i_stall(o_stall), .o_ctl_we(i_ctl_we),
    .o_key_we(i_key_we), .o_move_we(i_move_we), .o_move_re(i_move_re),
    .o_addr(ad), .o_wdata(wd), .o_hang(hang));
  initial forever #20 i_mclk = ~i_mclk;
  always @(negedge i_mclk) begin
    if (o_external_data_ram_we === 1'b1) xa = o_external_data_ram_addr;
    if (o_external_data_ram_re === 1'b1) xr++;
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_code_addr <= a;
    repeat (3) @(negedge i_mclk);
    chk("array byte", {8'h00, e}, {8'h00, o_code_rdata});
  endtask : rd
  task automatic do_reset();
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
  endtask : do_reset
  task automatic t_erase();
    core.wr(0, 16'h0000, 8'h03);
    core.op(16'h0123, 8'h55);
    rd(14'h0000, 8'hFF);
    rd(14'h01FF, 8'hFF);
    chk("control", 16'h0003, {8'h00, o_psc});
  endtask : t_erase
  task automatic t_prog();
    core.wr(0, 16'h0000, 8'h01);
    core.op(16'h0010, 8'hF0);
    rd(14'h0010, 8'hF0);
    rd(14'h0011, 8'hFF);
    core.wr(1, 16'h0000, 8'hA5);
    repeat (25) @(posedge i_mclk);
    core.wr(1, 16'h0000, 8'hF1);
    core.wr(2, 16'h0010, 8'h3C);
    rd(14'h0010, 8'h30);
    core.wr(2, 16'h0010, 8'h00);
    chk("lockout", 16'h0001, {15'h0, o_locked_out});
    rd(14'h0010, 8'h30);
  endtask : t_prog
  task automatic t_key_dbg();
    core.wr(1, 16'h0000, 8'hF1);
    core.wr(0, 16'h0000, 8'h01);
    chk("lockout", 16'h0001, {15'h0, o_locked_out});
    core.op(16'h0010, 8'h00);
    rd(14'h0010, 8'h30);
    @(posedge i_mclk);
    i_dbg_we <= 1'b1;
    i_dbg_addr <= 14'h0011;
    i_dbg_wdata <= 8'h81;
    @(posedge i_mclk);
    i_dbg_we <= 1'b0;
    repeat (12) @(posedge i_mclk);
    rd(14'h0011, 8'h81);
  endtask : t_key_dbg
  task automatic t_external_data_ram();
    core.wr(2, 16'hBEEF, 8'h5A);
    core.wr(3, 16'h0010, 8'h00);
    @(negedge i_mclk);
    chk("external_data_ram addr", 16'hBEEF, xa);
    chk("external_data_ram reads", 16'h0001, xr[15:0]);
    core.wr(0, 16'h0000, 8'h01);
    core.wr(2, 16'h3E00, 8'h00);
    chk("error flag", 16'h0001, {15'h0, o_nv_error_flag});
    core.wr(0, 16'h0000, 8'h00);
    core.wr(2, 16'h1234, 8'h77);
    @(negedge i_mclk);
    chk("external_data_ram addr", 16'h1234, xa);
  endtask : t_external_data_ram
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  always @(posedge hang) begin
    bad_count++;
    report_and_stop();
  end
  initial begin
    do_reset();
    t_erase();
    t_prog();
    do_reset();
    t_key_dbg();
    do_reset();
    t_external_data_ram();
    report_and_stop();
  end
endmodule : test_flash_program_erase_keyed_sequencer
bind fks_sequencer fks_sequencer_assertions u_chk (.i_mclk, .i_reset_n,
  .i_ctl_we, .i_ctl_wdata, .i_move_we, .i_move_re, .o_psc, .o_stall,
  .o_external_data_ram_we, .o_external_data_ram_re, .o_nv_error_flag, .o_locked_out);
